//--- cwph_top.v
`timescale 1ns/1ns
`include "cwph_defs.vh"
// Path 0 is the up path: lower port in, upper port out.
// Path 1 is the down path: upper port in, lower port out.
module cwph_top
(
   input  wire        clk,
   input  wire        rst,
   input  wire        dual_uart_en,
   input  wire        alive_en,
   input  wire [4:0]  chain_addr_field,
   input  wire [15:0] rd_word0,
   input  wire [15:0] rd_word1,
   input  wire [7:0]  rd_dc_flags,
   input  wire [15:0] status_one_reg,
   input  wire [15:0] alert_mask,
   input  wire        alert_clr,
   input  wire        lower_port_rx_valid,
   input  wire        lower_port_rx_sof,
   input  wire [7:0]  lower_port_rx_data,
   input  wire        upper_port_rx_valid,
   input  wire        upper_port_rx_sof,
   input  wire [7:0]  upper_port_rx_data,
   output wire        upper_port_tx_valid,
   output wire        upper_port_tx_sof,
   output wire [7:0]  upper_port_tx_data,
   output wire        lower_port_tx_valid,
   output wire        lower_port_tx_sof,
   output wire [7:0]  lower_port_tx_data,
   output wire        write_path_select,
   output wire        up_write_grant,
   output wire        down_write_grant,
   output wire        dual_path_cmd_alert
);
   localparam [2:0] K_PASS  = 3'd0;
   localparam [2:0] K_READ  = 3'd1;
   localparam [2:0] K_DOWN  = 3'd2;
   localparam [2:0] K_UP    = 3'd3;
   localparam [2:0] K_ALERT = 3'd4;

   reg         wp_q;
   reg         alert_q;
   wire [1:0]  rx_v;
   wire [1:0]  rx_s;
   wire [15:0] rx_d;
   wire [1:0]  tx_v;
   wire [1:0]  tx_s;
   wire [15:0] tx_d;
   wire [1:0]  go_down;
   wire [1:0]  go_up;
   wire [1:0]  bad_cmd;
   wire [15:0] stat_masked;

   assign rx_v = {upper_port_rx_valid, lower_port_rx_valid};
   assign rx_s = {upper_port_rx_sof, lower_port_rx_sof};
   assign rx_d = {upper_port_rx_data, lower_port_rx_data};
   assign upper_port_tx_valid = tx_v[0];
   assign upper_port_tx_sof   = tx_s[0];
   assign upper_port_tx_data  = tx_d[7:0];
   assign lower_port_tx_valid = tx_v[1];
   assign lower_port_tx_sof   = tx_s[1];
   assign lower_port_tx_data  = tx_d[15:8];
   assign stat_masked = status_one_reg & alert_mask;

   assign write_path_select   = wp_q;
   assign dual_path_cmd_alert = alert_q;
   // Reads stay open on both paths; writes follow the owner in dual mode, single mode grants the up path
   assign up_write_grant   = ~dual_uart_en | wp_q;
   assign down_write_grant = dual_uart_en & ~wp_q;

   // Claim commands are exclusive by owner state, so never both at once
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         wp_q <= `CWPH_WP_RESET;
      else if (|go_down)
         wp_q <= 1'b0;
      else if (|go_up)
         wp_q <= 1'b1;
   end

   // Set wins over a clear in the same cycle
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         alert_q <= 1'b0;
      else if (|bad_cmd)
         alert_q <= 1'b1;
      else if (alert_clr)
         alert_q <= 1'b0;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : path
         wire       v = rx_v[g];
         wire       s = rx_s[g];
         wire [7:0] d = rx_d[8*g +: 8];
         wire [6:0] pos;
         wire [6:0] last_data;
         wire [6:0] dc_pos;
         wire [6:0] pec_pos;
         wire [6:0] alv_pos;
         wire [6:0] slot;
         wire [1:0] loc_k;
         wire [7:0] fill;
         wire [7:0] crc_nx;
         wire       is_dn;
         wire       is_up;
         wire       is_read;
         wire       is_alert;
         wire [7:0] crc_seed;
         wire       rd_edit;
         wire       at_data;
         wire       at_dc;
         wire       at_pec;
         wire       at_alv;
         wire       at_loc;
         wire       own_loc;
         wire       at_st_lo;
         wire       at_st_hi;
         wire       at_a_pec;
         wire       at_tally;
         reg  [6:0] idx_q;
         reg  [2:0] kind_q;
         reg  [4:0] bs_q;
         reg        hit_q;
         reg        edit_q;
         reg  [7:0] dc_q;
         reg  [7:0] alive_q;
         reg  [7:0] crc_q;
         reg  [7:0] ob;
         reg        tv_q;
         reg        ts_q;
         reg  [7:0] td_q;
         reg  [2:0] kind_d;

         assign pos       = s ? 7'h00 : idx_q;
         assign last_data = 7'h02 + {1'b0, bs_q, 1'b0};
         assign dc_pos    = last_data + 7'h01;
         assign pec_pos   = last_data + 7'h02;
         assign alv_pos   = last_data + 7'h03;
         assign slot      = pos - `CWPH_POS_DATA;
         assign loc_k     = pos[1:0] - 2'd1;
         assign is_dn     = (d == `CWPH_CMD_DOWN);
         assign is_up     = (d == `CWPH_CMD_UP);
         assign is_read   = (d[2:0] == `CWPH_RD_LOW);
         assign is_alert  = (d == `CWPH_CMD_ALERT);
         assign at_tally  = edit_q && (pos == `CWPH_POS_TALLY);
         assign crc_seed  = s ? `CWPH_CRC_INIT : crc_q;

         // Block read slots; only the addressed node edits them
         assign rd_edit   = hit_q && (pos > `CWPH_POS_DEV + 7'h01);
         assign at_data   = (pos <= last_data);
         assign at_dc     = (pos == dc_pos);
         assign at_pec    = (pos == pec_pos);
         assign at_alv    = (pos == alv_pos) && alive_en;

         // Alert packet slots
         assign at_loc    = (pos >= `CWPH_POS_LOC0) &&
                            (pos <= `CWPH_POS_LOC3);
         assign own_loc   = (chain_addr_field[4:3] == loc_k);
         assign at_st_lo  = (pos == `CWPH_POS_ST_LO);
         assign at_st_hi  = (pos == `CWPH_POS_ST_HI);
         assign at_a_pec  = (pos == `CWPH_POS_A_PEC);

         // Valid only in dual mode, on the right path, from the other owner
         assign go_down[g] = v & s & dual_uart_en & is_dn
                             & (g == 1) & wp_q;
         assign go_up[g]   = v & s & dual_uart_en & is_up
                             & (g == 0) & ~wp_q;
         assign bad_cmd[g] = v & s & dual_uart_en
                             & ((is_dn & (g == 0)) | (is_up & (g == 1)));

         cwph_read_fill u_fill
         (
            .word0     (rd_word0),
            .word1     (rd_word1),
            .slot      (slot),
            .data_byte (fill)
         );

         cwph_crc8 u_crc
         (
            .crc_in  (crc_seed),
            .byte_in (ob),
            .crc_out (crc_nx)
         );

         always @*
         begin
            kind_d = K_PASS;
            if (is_read)
               kind_d = K_READ;
            else if (is_dn)
               kind_d = K_DOWN;
            else if (is_up)
               kind_d = K_UP;
            else if (is_alert)
               kind_d = K_ALERT;
         end

         always @*
         begin
            ob = d;
            case (kind_q)
               K_READ:
               begin
                  if (rd_edit)
                  begin
                     if (at_data)
                        ob = fill;
                     else if (at_dc)
                        ob = dc_q | rd_dc_flags;
                     else if (at_pec)
                        ob = crc_q;
                     else if (at_alv)
                        ob = alive_q + 8'h01;
                  end
               end
               K_DOWN, K_UP:
               begin
                  if (at_tally)
                     ob = {`CWPH_TALLY_PAD, d[4:0] + 5'h01};
               end
               K_ALERT:
               begin
                  if (at_loc)
                  begin
                     if (own_loc)
                        ob = d | (8'h01 << chain_addr_field[2:0]);
                  end
                  else if (at_st_lo)
                     ob = d | stat_masked[7:0];
                  else if (at_st_hi)
                     ob = d | stat_masked[15:8];
                  else if (at_a_pec)
                     ob = crc_q;
               end
               default:
                  ob = d;
            endcase
         end

         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               idx_q   <= 7'h00;
               kind_q  <= K_PASS;
               bs_q    <= 5'h00;
               hit_q   <= 1'b0;
               edit_q  <= 1'b0;
               dc_q    <= 8'h00;
               alive_q <= 8'h00;
               crc_q   <= `CWPH_CRC_INIT;
            end
            else if (v)
            begin
               idx_q <= (pos == 7'h7f) ? pos : pos + 7'h01;
               crc_q <= crc_nx;
               if (s)
               begin
                  kind_q <= kind_d;
                  bs_q   <= d[7:3];
                  hit_q  <= 1'b0;
                  edit_q <= go_down[g] | go_up[g];
               end
               if (pos == `CWPH_POS_DEV)
                  hit_q <= (d == {3'b000, chain_addr_field}) &&
                           (bs_q != 5'h00);
               if (pos == `CWPH_POS_DATA)
                  dc_q <= d;
               if (pos == `CWPH_POS_ALIVE)
                  alive_q <= d;
            end
         end

         // One cycle of latency, no buffering
         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               tv_q <= 1'b0;
               ts_q <= 1'b0;
               td_q <= 8'h00;
            end
            else
            begin
               tv_q <= v;
               ts_q <= v & s;
               if (v)
                  td_q <= ob;
            end
         end

         assign tx_v[g]         = tv_q;
         assign tx_s[g]         = ts_q;
         assign tx_d[8*g +: 8]  = td_q;
      end
   endgenerate
endmodule

//--- cwph_defs.vh
`ifndef CWPH_DEFS_VH
`define CWPH_DEFS_VH
`define CWPH_CMD_DOWN    8'h09
`define CWPH_CMD_UP      8'h08
`define CWPH_CMD_ALERT   8'h21
`define CWPH_RD_LOW      3'b110
`define CWPH_FILL_A      8'hc2
`define CWPH_FILL_B      8'hd3
`define CWPH_WP_RESET    1'b1
`define CWPH_TALLY_PAD   3'b000
`define CWPH_CRC_INIT    8'h00
`define CWPH_CRC_POLY    8'h07
`define CWPH_POS_DEV     7'h01
`define CWPH_POS_DATA    7'h03
`define CWPH_POS_ALIVE   7'h05
`define CWPH_POS_TALLY   7'h02
`define CWPH_POS_LOC0    7'h01
`define CWPH_POS_LOC3    7'h04
`define CWPH_POS_ST_LO   7'h05
`define CWPH_POS_ST_HI   7'h06
`define CWPH_POS_A_PEC   7'h07
`endif

//--- cwph_crc8.v
`timescale 1ns/1ns
`include "cwph_defs.vh"
// One byte step of the packet check code, MSB first
module cwph_crc8
#(
   parameter [7:0] POLY = `CWPH_CRC_POLY
)
(
   input  wire [7:0] crc_in,
   input  wire [7:0] byte_in,
   output reg  [7:0] crc_out
);
   integer i;
   reg [7:0] c;
   always @*
   begin
      c = crc_in ^ byte_in;
      for (i = 0; i < 8; i = i + 1)
      begin
         c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
      end
      crc_out = c;
   end
endmodule

//--- cwph_read_fill.v
`timescale 1ns/1ns
// Picks the read byte for data slot j, low byte of each word first
module cwph_read_fill
(
   input  wire [15:0] word0,
   input  wire [15:0] word1,
   input  wire [6:0]  slot,
   output reg  [7:0]  data_byte
);
   always @*
   begin
      case (slot)
         7'h00:   data_byte = word0[7:0];
         7'h01:   data_byte = word0[15:8];
         7'h02:   data_byte = word1[7:0];
         7'h03:   data_byte = word1[15:8];
         // Only two words are sourced; larger blocks read zero
         default: data_byte = 8'h00;
      endcase
   end
endmodule

//--- cwph_chain_assertions.sv
`timescale 1ns/1ns
module cwph_checker
(
   input wire       clk,
   input wire       rst,
   input wire       dual_uart_en,
   input wire       lower_port_rx_valid,
   input wire       lower_port_rx_sof,
   input wire [7:0] lower_port_rx_data,
   input wire       upper_port_rx_valid,
   input wire       upper_port_rx_sof,
   input wire [7:0] upper_port_rx_data,
   input wire       upper_port_tx_valid,
   input wire [7:0] upper_port_tx_data,
   input wire       lower_port_tx_valid,
   input wire       lower_port_tx_sof,
   input wire [7:0] lower_port_tx_data,
   input wire       write_path_select,
   input wire       up_write_grant,
   input wire       down_write_grant,
   input wire       dual_path_cmd_alert
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire lc = lower_port_rx_valid && lower_port_rx_sof;
   wire uc = upper_port_rx_valid && upper_port_rx_sof;
   sequence dn_claim;
      uc && upper_port_rx_data == 8'h09 && dual_uart_en && write_path_select
      ##1 upper_port_rx_valid ##1 upper_port_rx_valid;
   endsequence
   sequence up_claim;
      lc && lower_port_rx_data == 8'h08 && dual_uart_en && !write_path_select
      ##1 lower_port_rx_valid ##1 lower_port_rx_valid;
   endsequence
   wp_after_reset_a: assert property ($fell(rst) |-> write_path_select)
      else $error("write path not up after reset");
   fwd_up_a: assert property (
      lower_port_rx_valid |=> upper_port_tx_valid)
      else $error("up path byte not forwarded");
   fwd_dn_a: assert property (
      uc |=> lower_port_tx_valid && lower_port_tx_sof)
      else $error("down path frame start not forwarded");
   grant_one_a: assert property (
      dual_uart_en |-> up_write_grant == write_path_select &&
      down_write_grant == !write_path_select)
      else $error("write grant does not follow owner");
   dn_tally_a: assert property (dn_claim |=> !write_path_select &&
      lower_port_tx_data == (($past(upper_port_rx_data) + 8'h01) & 8'h1f))
      else $error("claim down tally or owner wrong");
   up_tally_a: assert property (up_claim |=> write_path_select &&
      upper_port_tx_data == (($past(lower_port_rx_data) + 8'h01) & 8'h1f))
      else $error("claim up tally or owner wrong");
   wrong_dn_a: assert property (dual_uart_en && lc &&
      lower_port_rx_data == 8'h09 |=>
      dual_path_cmd_alert && $stable(write_path_select))
      else $error("claim down on up path mishandled");
   wrong_up_a: assert property (dual_uart_en && uc &&
      upper_port_rx_data == 8'h08 |=>
      dual_path_cmd_alert && $stable(write_path_select))
      else $error("claim up on down path mishandled");
   single_a: assert property (!dual_uart_en && (lc || uc) |=>
      $stable(write_path_select))
      else $error("owner changed outside dual mode");
endmodule
bind cwph_top cwph_checker u_chk (.*);

//--- cwph_chain_model.sv
`timescale 1ns/1ns
module cwph_chain_model
(
   input wire       clk,
   output reg       lower_port_rx_valid,
   output reg       lower_port_rx_sof,
   output reg [7:0] lower_port_rx_data,
   output reg       upper_port_rx_valid,
   output reg       upper_port_rx_sof,
   output reg [7:0] upper_port_rx_data
);
   initial
   begin
      lower_port_rx_valid = 1'b0;
      lower_port_rx_sof = 1'b0;
      lower_port_rx_data = 8'h00;
      upper_port_rx_valid = 1'b0;
      upper_port_rx_sof = 1'b0;
      upper_port_rx_data = 8'h00;
   end
   // Idle lines flip so stale data never looks valid
   task put(input p, input v, input s, input [7:0] d);
      @(posedge clk);
      #1;
      lower_port_rx_valid = v && !p;
      lower_port_rx_sof = s && !p;
      lower_port_rx_data = (v && !p) ? d : ~lower_port_rx_data;
      upper_port_rx_valid = v && p;
      upper_port_rx_sof = s && p;
      upper_port_rx_data = (v && p) ? d : ~upper_port_rx_data;
   endtask
endmodule

//--- tb.sv
`timescale 1ns/1ns
module tb;
   reg         clk, rst, dual_uart_en, alive_en, alert_clr;
   reg  [4:0]  chain_addr_field;
   reg  [15:0] rd_word0, rd_word1, status_one_reg, alert_mask, m;
   reg  [7:0]  rd_dc_flags;
   reg  [8:0]  e;
   wire        lower_port_rx_valid, lower_port_rx_sof;
   wire        upper_port_rx_valid, upper_port_rx_sof;
   wire [7:0]  lower_port_rx_data, upper_port_rx_data;
   wire        upper_port_tx_valid, upper_port_tx_sof;
   wire        lower_port_tx_valid, lower_port_tx_sof;
   wire [7:0]  upper_port_tx_data, lower_port_tx_data;
   wire        write_path_select, up_write_grant;
   wire        down_write_grant, dual_path_cmd_alert;
   reg  [31:0] rs;
   reg  [7:0]  fi [0:9];
   reg  [7:0]  fo [0:9];
   reg  [8:0]  q_up [$];
   reg  [8:0]  q_lo [$];
   integer     err_count, tests_run;
   cwph_top u_dut (.*);
   cwph_chain_model u_chain (.*);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function [31:0] xs(input [31:0] x);
      xs = x ^ (x << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   task chk(input [7:0] s, input [7:0] x);
      tests_run++;
      if (s !== x)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
      end
   endtask
   task st(input w, input a, input string n);
      @(negedge clk);
      chk({7'h00, write_path_select}, {7'h00, w});
      chk({7'h00, dual_path_cmd_alert}, {7'h00, a});
      chk({7'h00, up_write_grant}, {7'h00, ~dual_uart_en | w});
      chk({7'h00, down_write_grant}, {7'h00, dual_uart_en & ~w});
      $display("test %s done", n);
      @(posedge clk);
      #1;
   endtask
   task xfer(input p, input integer n);
      integer k;
      for (k = 0; k < n; k++)
      begin
         if (p)
            q_lo.push_back({k == 0, fo[k]});
         else
            q_up.push_back({k == 0, fo[k]});
         u_chain.put(p, 1'b1, k == 0, fi[k]);
      end
      u_chain.put(1'b0, 1'b0, 1'b0, 8'h00);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task packet_check_byte(input integer n);
      integer k, b;
      fo[n] = 8'h00;
      for (k = 0; k < n; k++)
      begin
         fo[n] = fo[n] ^ fo[k];
         for (b = 0; b < 8; b++)
            fo[n] = fo[n][7] ? (fo[n] << 1) ^ 8'h07 : fo[n] << 1;
      end
   endtask
   // Tally is {000, five bits}; the increment wraps inside five bits
   task claim(input p, input [7:0] c, input inc, input [4:0] t);
      fi[0] = c;
      fi[1] = 8'h00;
      fi[2] = {3'b000, t};
      fo[0] = c;
      fo[1] = 8'h00;
      fo[2] = {3'b000, inc ? t + 5'h01 : t};
      xfer(p, 3);
   endtask
   task clr;
      alert_clr = 1'b1;
      @(posedge clk);
      #1;
      alert_clr = 1'b0;
   endtask
   always @(negedge clk)
   begin
      if (upper_port_tx_valid === 1'b1)
      begin
         e = q_up.size() ? q_up.pop_front() : {9{1'bx}};
         chk(upper_port_tx_data, e[7:0]);
         chk({7'h00, upper_port_tx_sof}, {7'h00, e[8]});
      end
      if (lower_port_tx_valid === 1'b1)
      begin
         e = q_lo.size() ? q_lo.pop_front() : {9{1'bx}};
         chk(lower_port_tx_data, e[7:0]);
         chk({7'h00, lower_port_tx_sof}, {7'h00, e[8]});
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_count++;
      end_of_test;
   end
   initial
   begin
      {err_count, tests_run, alive_en, alert_clr} = 0;
      rs = 32'd70993;
      rst = 1'b1;
      dual_uart_en = 1'b1;
      chain_addr_field = 5'h0d;
      {rd_word0, rd_word1, status_one_reg, alert_mask} = 0;
      rd_dc_flags = 8'h00;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      st(1'b1, 1'b0, "reset");
      claim(1'b1, 8'h09, 1'b1, 5'h1f);
      st(1'b0, 1'b0, "claim down");
      rs = xs(rs);
      claim(1'b1, 8'h09, 1'b0, rs[4:0]);
      st(1'b0, 1'b0, "down owner again");
      claim(1'b1, 8'h08, 1'b0, rs[9:5]);
      st(1'b0, 1'b1, "claim up on down");
      clr;
      claim(1'b0, 8'h09, 1'b0, rs[14:10]);
      st(1'b0, 1'b1, "claim down on up");
      clr;
      claim(1'b0, 8'h08, 1'b1, rs[19:15]);
      st(1'b1, 1'b0, "claim up");
      claim(1'b0, 8'h08, 1'b0, rs[24:20]);
      st(1'b1, 1'b0, "up owner again");
      dual_uart_en = 1'b0;
      claim(1'b1, 8'h09, 1'b0, rs[29:25]);
      st(1'b1, 1'b0, "single mode");
      alive_en = 1'b1;
      rs = xs(rs);
      rd_word0 = rs[15:0];
      rd_word1 = rs[31:16];
      rs = xs(rs);
      rd_dc_flags = rs[7:0];
      fi = '{8'h16, 8'h0d, 8'h12, rs[15:8], 8'h5a, rs[23:16],
             8'hc2, 8'hd3, 8'hc2, 8'hd3};
      fo = '{8'h16, 8'h0d, 8'h12, rd_word0[7:0], rd_word0[15:8],
             rd_word1[7:0], rd_word1[15:8], rs[15:8] | rs[7:0], 8'h00,
             rs[23:16] + 8'h01};
      packet_check_byte(8);
      xfer(1'b0, 10);
      st(1'b1, 1'b0, "block read");
      rs = xs(rs);
      status_one_reg = rs[15:0];
      alert_mask = rs[31:16];
      m = rs[15:0] & rs[31:16];
      fi = '{8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h41, 8'h80, 8'h77,
             8'h00, 8'h00};
      fo = '{8'h21, 8'h00, 8'h20, 8'h00, 8'h00, 8'h41 | m[7:0],
             8'h80 | m[15:8], 8'h00, 8'h00, 8'h00};
      packet_check_byte(7);
      xfer(1'b1, 8);
      st(1'b1, 1'b0, "alert packet");
      // Every noted byte must have come out
      chk({7'h00, (q_up.size() != 0) || (q_lo.size() != 0)}, 8'h00);
      end_of_test;
   end
endmodule
